// file: hdl/ppm_pkg.sv
// Constants and types for the port pin function multiplexer
package ppm_pkg;
   // ---------------------------------------------------------------
   // Port widths
   // ---------------------------------------------------------------
   localparam int SPI_PORT_W = 3;
   localparam int OSC_PORT_W = 2;
   // ---------------------------------------------------------------
   // Bit positions within the ports
   // ---------------------------------------------------------------
   localparam int SPI_BIT_A  = 0; // Data out when master
   localparam int SPI_BIT_B  = 1; // Data in when master
   localparam int SPI_BIT_C  = 2; // Serial clock
   localparam int OSC_BIT_Z  = 0; // Amp output / divided clock
   localparam int OSC_BIT_O  = 1; // Amp input
   localparam int TRIM_CLKEN_BIT = 6; // Clock-output enable in trim reg
   // ---------------------------------------------------------------
   // Pin output-type modes, reset values
   // ---------------------------------------------------------------
   typedef enum logic [1:0]
   {
      PPM_QUASI  = 2'h0,
      PPM_PUSHPL = 2'h1,
      PPM_INONLY = 2'h2,
      PPM_OPENDR = 2'h3
   } ppm_mode_t;
   localparam logic [1:0] MODE_RST  = 2'h2; // Input only, no pull-up
   localparam logic       LATCH_RST = 1'h1;
   // ---------------------------------------------------------------
   // CPU clock source codes
   // ---------------------------------------------------------------
   typedef enum logic [1:0]
   {
      PPM_SRC_RC   = 2'h0,
      PPM_SRC_WDT  = 2'h1,
      PPM_SRC_EXT  = 2'h2,
      PPM_SRC_XTAL = 2'h3
   } ppm_src_t;
endpackage : ppm_pkg

// file: hdl/ppm_pin_cell.sv
// One configurable port pin: latch, mode and pin driver
`timescale 1ns/100ps
`default_nettype none
module ppm_pin_cell
(
   input  wire logic       clk,      // System clock
   input  wire logic       rst,      // Synchronous reset, high
   input  wire logic       ce,       // Clock enable
   input  wire logic       wr_latch, // Latch write strobe
   input  wire logic       wr_mode,  // Mode write strobe
   input  wire logic       wdata,    // Latch write value
   input  wire logic [1:0] wmode,    // Mode write value
   input  wire logic       ovr,      // Special function owns the pin
   input  wire logic       ovr_out,  // Special function drive level
   input  wire logic       ovr_oe,   // Special function drives pin
   output logic            pin_o,    // Pin output level
   output logic            pin_oe_n, // Pin output enable, low drives
   output logic            pull_up,  // Weak pull-up request
   output logic            latch,    // Latch value
   output logic [1:0]      mode      // Mode value
);
   logic       latch_q;
   logic [1:0] mode_q;
   // ---------------------------------------------------------------
   // Latch and mode registers
   // ---------------------------------------------------------------
   // Reset forces input only with pull-up off
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         latch_q <= ppm_pkg::LATCH_RST;
         mode_q  <= ppm_pkg::MODE_RST;
      end
      else if (ce)
      begin
         if (wr_latch)
            latch_q <= wdata;
         if (wr_mode)
            mode_q <= wmode;
      end
   end
   // ---------------------------------------------------------------
   // Driver decode
   // ---------------------------------------------------------------
   wire port_drive = (mode_q == ppm_pkg::PPM_PUSHPL) ||
                     (mode_q == ppm_pkg::PPM_QUASI && !latch_q) ||
                     (mode_q == ppm_pkg::PPM_OPENDR && !latch_q);
   // Owner override hides latch and mode while claimed
   assign pin_o    = ovr ? ovr_out : latch_q;
   assign pin_oe_n = ovr ? !ovr_oe : !port_drive;
   assign pull_up  = !ovr && (mode_q == ppm_pkg::PPM_QUASI);
   assign latch    = latch_q;
   assign mode     = mode_q;
endmodule : ppm_pin_cell
`default_nettype wire

// file: hdl/ppm_mux.sv
// Pin function multiplexer for the SPI-shared and oscillator ports
`timescale 1ns/100ps
`default_nettype none
module ppm_mux
(
   input  wire logic        CLOCK,        // 50 MHz system clock
   input  wire logic        RST,          // Synchronous reset, high
   input  wire logic        CE,           // Clock enable
   // Port register access
   input  wire logic [2:0]  SPI_LATCH_WE, // Per-pin latch write
   input  wire logic [2:0]  SPI_MODE_WE,  // Per-pin mode write
   input  wire logic [1:0]  OSC_LATCH_WE, // Per-pin latch write
   input  wire logic [1:0]  OSC_MODE_WE,  // Per-pin mode write
   input  wire logic        WR_DATA,      // Latch write value
   input  wire logic [1:0]  WR_MODE,      // Mode write value
   output logic [2:0]       SPI_LATCH,    // SPI port latches
   output logic [1:0]       OSC_LATCH,    // Oscillator port latches
   output logic [5:0]       SPI_MODES,    // Mode pairs, pin 0 low
   output logic [3:0]       OSC_MODES,    // Mode pairs, pin 0 low
   output logic [2:0]       SPI_PORT_IN,  // Synchronised pin levels
   output logic [1:0]       OSC_PORT_IN,  // Synchronised pin levels
   // SPI engine side
   input  wire logic        SPI_EN,       // SPI unit enabled
   input  wire logic        SPI_MASTER,   // Master when high
   input  wire logic        SPI_DO,       // Master out data
   input  wire logic        SPI_SO,       // Slave out data
   input  wire logic        SPI_SCK_OUT,  // Clock when master
   output logic             SPI_MOSI_IN,  // Data seen as slave
   output logic             SPI_MISO_IN,  // Data seen as master
   output logic             SPI_SCK_IN,   // Clock seen as slave
   // Clock configuration
   input  wire logic        TRIM_CLKEN,   // Clock-output enable bit
   input  wire logic [1:0]  CPU_CLK_SRC,  // CPU clock source code
   input  wire logic        RTC_XTAL,     // Crystal clocks the timer
   input  wire logic        OSC_AMP_OUT,  // Amplifier output level
   output logic             OSC_AMP_IN,   // Level to amplifier input
   output logic             DIVIDED_CLOCK_OUTPUT_ACTIVE, // Halved clock on pin
   // Pins
   input  wire logic [2:0]  SPI_PIN_I,    // SPI port pin inputs
   output logic [2:0]       SPI_PIN_O,    // SPI port pin outputs
   output logic [2:0]       SPI_PIN_OE_N, // Low drives the pin
   output logic [2:0]       SPI_PULLUP,   // Pull-up requests
   input  wire logic [1:0]  OSC_PIN_I,    // Oscillator pin inputs
   output logic [1:0]       OSC_PIN_O,    // Oscillator pin outputs
   output logic [1:0]       OSC_PIN_OE_N, // Low drives the pin
   output logic [1:0]       OSC_PULLUP    // Pull-up requests
);
   // ---------------------------------------------------------------
   // Input synchronisers
   // ---------------------------------------------------------------
   logic [4:0] sync1_q;
   logic [4:0] sync2_q;
   logic       div_q;
   // Pins are asynchronous, so two stages before any use
   always_ff @(posedge CLOCK)
   begin
      if (RST)
      begin
         sync1_q <= 5'h00;
         sync2_q <= 5'h00;
      end
      else if (CE)
      begin
         sync1_q <= {OSC_PIN_I, SPI_PIN_I};
         sync2_q <= sync1_q;
      end
   end
   assign SPI_PORT_IN = sync2_q[2:0];
   assign OSC_PORT_IN = sync2_q[4:3];
   // ---------------------------------------------------------------
   // Clock source decode
   // ---------------------------------------------------------------
   wire xtal_sel   = (CPU_CLK_SRC == ppm_pkg::PPM_SRC_XTAL);
   wire rc_or_wdt  = (CPU_CLK_SRC == ppm_pkg::PPM_SRC_RC) ||
                     (CPU_CLK_SRC == ppm_pkg::PPM_SRC_WDT);
   wire ext_sel    = (CPU_CLK_SRC == ppm_pkg::PPM_SRC_EXT);
   // Crystal pins busy when crystal drives CPU or timer
   wire amp_claim  = xtal_sel || RTC_XTAL;
   wire divided_clock_output_ok  = TRIM_CLKEN && !RTC_XTAL && !xtal_sel &&
                     (rc_or_wdt || ext_sel);
   wire in_claim   = !(rc_or_wdt && !RTC_XTAL);
   // ---------------------------------------------------------------
   // Halved CPU clock
   // ---------------------------------------------------------------
   // Toggles every enabled cycle while divided_clock_output_ok, else held low; a register keeps the pin glitch free
   always_ff @(posedge CLOCK)
   begin
      if (RST)
         div_q <= 1'h0;
      else if (CE)
         div_q <= divided_clock_output_ok ? !div_q : 1'h0;
   end
   assign DIVIDED_CLOCK_OUTPUT_ACTIVE = divided_clock_output_ok;
   // ---------------------------------------------------------------
   // SPI pin ownership and direction
   // ---------------------------------------------------------------
   wire [2:0] spi_ovr_out = {SPI_SCK_OUT, SPI_SO, SPI_DO};
   wire [2:0] spi_ovr_oe  = {SPI_MASTER, !SPI_MASTER, SPI_MASTER};
   assign SPI_MOSI_IN = sync2_q[ppm_pkg::SPI_BIT_A];
   assign SPI_MISO_IN = sync2_q[ppm_pkg::SPI_BIT_B];
   assign SPI_SCK_IN  = sync2_q[ppm_pkg::SPI_BIT_C];
   // ---------------------------------------------------------------
   // Oscillator pin ownership
   // ---------------------------------------------------------------
   wire [1:0] osc_ovr     = {in_claim, amp_claim || divided_clock_output_ok};
   wire [1:0] osc_ovr_out = {1'h0, divided_clock_output_ok ? div_q : OSC_AMP_OUT};
   wire [1:0] osc_ovr_oe  = {1'h0, 1'h1};
   assign OSC_AMP_IN = sync2_q[3 + ppm_pkg::OSC_BIT_O];
   // ---------------------------------------------------------------
   // Pin cells
   // ---------------------------------------------------------------
   genvar g;
   generate
      for (g = 0; g < ppm_pkg::SPI_PORT_W; g++)
      begin : g_spi
         ppm_pin_cell u_cell
         (
            .clk      (CLOCK),
            .rst      (RST),
            .ce       (CE),
            .wr_latch (SPI_LATCH_WE[g]),
            .wr_mode  (SPI_MODE_WE[g]),
            .wdata    (WR_DATA),
            .wmode    (WR_MODE),
            .ovr      (SPI_EN),
            .ovr_out  (spi_ovr_out[g]),
            .ovr_oe   (spi_ovr_oe[g]),
            .pin_o    (SPI_PIN_O[g]),
            .pin_oe_n (SPI_PIN_OE_N[g]),
            .pull_up  (SPI_PULLUP[g]),
            .latch    (SPI_LATCH[g]),
            .mode     (SPI_MODES[2*g +: 2])
         );
      end
      for (g = 0; g < ppm_pkg::OSC_PORT_W; g++)
      begin : g_osc
         ppm_pin_cell u_cell
         (
            .clk      (CLOCK),
            .rst      (RST),
            .ce       (CE),
            .wr_latch (OSC_LATCH_WE[g]),
            .wr_mode  (OSC_MODE_WE[g]),
            .wdata    (WR_DATA),
            .wmode    (WR_MODE),
            .ovr      (osc_ovr[g]),
            .ovr_out  (osc_ovr_out[g]),
            .ovr_oe   (osc_ovr_oe[g]),
            .pin_o    (OSC_PIN_O[g]),
            .pin_oe_n (OSC_PIN_OE_N[g]),
            .pull_up  (OSC_PULLUP[g]),
            .latch    (OSC_LATCH[g]),
            .mode     (OSC_MODES[2*g +: 2])
         );
      end
   endgenerate
endmodule : ppm_mux
`default_nettype wire

// file: tb/ppm_mux_asserts.sv
// Port-level assertions for the pin function multiplexer
`timescale 1ns/100ps
`default_nettype none
module ppm_mux_asserts
(
   input wire logic       CLOCK,         // System clock
   input wire logic       RST,           // Synchronous reset
   input wire logic       CE,            // Clock enable
   input wire logic [2:0] SPI_MODE_WE,   // Mode write strobes
   input wire logic [1:0] WR_MODE,       // Mode write value
   input wire logic [5:0] SPI_MODES,     // SPI port modes
   input wire logic [3:0] OSC_MODES,     // Oscillator port modes
   input wire logic [2:0] SPI_PULLUP,    // SPI pull-ups
   input wire logic [1:0] OSC_PULLUP,    // Oscillator pull-ups
   input wire logic       SPI_EN,        // SPI owns the port
   input wire logic       SPI_MASTER,    // Master role
   input wire logic [2:0] SPI_PIN_OE_N,  // SPI pin enables
   input wire logic       TRIM_CLKEN,    // Clock-output enable
   input wire logic [1:0] CPU_CLK_SRC,   // CPU clock source
   input wire logic       RTC_XTAL,      // Crystal clocks timer
   input wire logic       OSC_AMP_OUT,   // Amplifier output
   input wire logic       DIVIDED_CLOCK_OUTPUT_ACTIVE, // Halved clock on pin
   input wire logic [1:0] OSC_PIN_O,     // Oscillator pin levels
   input wire logic [1:0] OSC_PIN_OE_N   // Oscillator pin enables
);
   // -------------------------------------------------------------
   // Properties, all in the system clock domain
   // -------------------------------------------------------------
   default clocking cb @(posedge CLOCK); endclocking
   default disable iff (RST);
   // Halved clock is only legal off a non-crystal source
   wire logic co_ok = TRIM_CLKEN && CPU_CLK_SRC != 2'h3 && !RTC_XTAL;
   sequence s_run;
      DIVIDED_CLOCK_OUTPUT_ACTIVE && CE;
   endsequence
   a_rst_modes: assert property ($fell(RST) |->
      SPI_MODES == 6'h2a && OSC_MODES == 4'ha) else $error("reset modes");
   a_rst_pull: assert property ($fell(RST) |->
      SPI_PULLUP == 3'h0 && OSC_PULLUP == 2'h0) else $error("reset pull");
   a_mosi_dir: assert property (SPI_EN |->
      SPI_PIN_OE_N[0] == !SPI_MASTER) else $error("data out dir");
   a_miso_dir: assert property (SPI_EN |->
      SPI_PIN_OE_N[1] == SPI_MASTER) else $error("data in dir");
   a_sck_dir: assert property (SPI_EN |->
      SPI_PIN_OE_N[2] == !SPI_MASTER) else $error("clock dir");
   a_clk_allow: assert property (DIVIDED_CLOCK_OUTPUT_ACTIVE == co_ok)
      else $error("clock out gating");
   a_clk_toggle: assert property (s_run ##1 DIVIDED_CLOCK_OUTPUT_ACTIVE |->
      !OSC_PIN_OE_N[0] && OSC_PIN_O[0] != $past(OSC_PIN_O[0]))
      else $error("clock out toggle");
   a_xtal_pin: assert property (CPU_CLK_SRC == 2'h3 || RTC_XTAL |->
      !OSC_PIN_OE_N[0] && OSC_PIN_O[0] == OSC_AMP_OUT) else $error("amp out");
   a_amp_in: assert property (!(CPU_CLK_SRC < 2'h2 && !RTC_XTAL) |->
      OSC_PIN_OE_N[1]) else $error("amp in claim");
   a_mode_wr: assert property (CE && SPI_MODE_WE == 3'h1 |=>
      SPI_MODES[1:0] == $past(WR_MODE) &&
      SPI_MODES[5:2] == $past(SPI_MODES[5:2])) else $error("mode write");
endmodule : ppm_mux_asserts
bind ppm_mux ppm_mux_asserts u_ppm_mux_asserts (.*);
`default_nettype wire

// file: tb/ppm_peer.sv
// Far-side SPI peer that also resolves the shared port wires
`timescale 1ns/100ps
`default_nettype none
module ppm_peer
(
   input  wire logic       clk,  // System clock
   input  wire logic       act,  // Peer frame in progress
   input  wire logic [2:0] oe_n, // Device enables, low drives
   input  wire logic [2:0] o,    // Device drive levels
   input  wire logic [2:0] pu,   // Device pull-up requests
   output logic [2:0]      pin   // Resolved wire levels
);
   // Known start so a released wire never locks at unknown
   logic [2:0] pat_q  = 3'h0; // Peer levels, bit 2 is its clock
   logic [2:0] last_q = 3'h0; // Last wire levels
   // Peer clock stands still outside frames
   always_ff @(posedge clk)
   begin
      pat_q  <= act ? {~pat_q[2], pat_q[0], pat_q[2] ^ pat_q[1]} : 3'h0;
      last_q <= pin;
   end
   // Released wire: peer level in a frame, else pull-up level or inverse of last level
   assign pin = (~oe_n & o) | (oe_n & (act ? pat_q : pu | ~last_q));
endmodule : ppm_peer
`default_nettype wire

// file: tb/tb_top.sv
// Self-checking bench for the pin function multiplexer
`timescale 1ns/100ps
`default_nettype none
module tb_top;
   logic       CLOCK, RST, CE, WR_DATA, SPI_EN, SPI_MASTER, SPI_DO, act;
   logic       SPI_SO, SPI_SCK_OUT, TRIM_CLKEN, RTC_XTAL, OSC_AMP_OUT;
   logic       DIVIDED_CLOCK_OUTPUT_ACTIVE, SPI_MOSI_IN, SPI_MISO_IN, SPI_SCK_IN;
   logic       OSC_AMP_IN;
   logic [1:0] WR_MODE, CPU_CLK_SRC, OSC_PIN_I, OSC_LATCH_WE, OSC_MODE_WE;
   logic [1:0] OSC_LATCH, OSC_PORT_IN, OSC_PIN_O, OSC_PIN_OE_N, OSC_PULLUP;
   logic [2:0] SPI_LATCH_WE, SPI_MODE_WE, SPI_LATCH, SPI_PORT_IN, SPI_PIN_I;
   logic [2:0] SPI_PIN_O, SPI_PIN_OE_N, SPI_PULLUP, h1, h2;
   logic [5:0] SPI_MODES, sm;
   logic [3:0] OSC_MODES;
   logic [1:0] m;
   int         num_errors = 0, n_compared = 0, i, k;
   ppm_mux  u_ppm_mux (.*);
   ppm_peer u_ppm_peer (.clk(CLOCK), .act(act), .oe_n(SPI_PIN_OE_N),
                        .o(SPI_PIN_O), .pu(SPI_PULLUP), .pin(SPI_PIN_I));
   // -------------------------------------------------------------
   // Helpers
   // -------------------------------------------------------------
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_compared++;
      if (got !== exp)
      begin
         num_errors++;
         $display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
      end
   endtask : chk
   // One write, strobes dropped at the following edge
   task automatic wr(input logic [2:0] sw, input logic [1:0] ow,
                     input logic [1:0] md);
      {SPI_MODE_WE, SPI_LATCH_WE, OSC_MODE_WE, OSC_LATCH_WE} <= {sw, sw, ow, ow};
      WR_MODE <= md;
      @(posedge CLOCK);
      {SPI_MODE_WE, SPI_LATCH_WE, OSC_MODE_WE, OSC_LATCH_WE} <= 10'h0;
      @(posedge CLOCK);
   endtask : wr
   function automatic logic [2:0] spi_oe(input logic ms);
      return ms ? 3'h2 : 3'h5; // Master drives data out and clock
   endfunction : spi_oe
   task automatic finish_test;
      $display("errors %0d compared %0d", num_errors, n_compared);
      if (num_errors == 0 && n_compared > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : finish_test
   // Clock, two-flop history of the wires, and a hang guard
   initial
   begin
      CLOCK = 1'b0;
      forever #10 CLOCK = ~CLOCK;
   end
   always @(posedge CLOCK) {h2, h1} <= {h1, SPI_PIN_I};
   initial
   begin
      #400000 num_errors++;
      finish_test();
   end
   // -------------------------------------------------------------
   // Main sequence
   // -------------------------------------------------------------
   initial
   begin
      {RST, CE, WR_DATA, SPI_EN, SPI_MASTER, SPI_DO, act} = 7'h60;
      {SPI_SO, SPI_SCK_OUT, TRIM_CLKEN, RTC_XTAL, OSC_AMP_OUT} = 5'h0;
      {WR_MODE, CPU_CLK_SRC, OSC_PIN_I, OSC_LATCH_WE, OSC_MODE_WE} = 10'h0;
      {SPI_LATCH_WE, SPI_MODE_WE} = 6'h0;
      void'($urandom(66));
      repeat (10) @(posedge CLOCK);
      RST <= 1'b0;
      @(negedge CLOCK);
      chk({2'h0, SPI_MODES}, 8'h2a);
      chk({4'h0, OSC_MODES}, 8'h0a);
      chk({SPI_PULLUP, OSC_PULLUP, SPI_PIN_OE_N}, 8'h07);
      sm = 6'h2a;
      for (i = 0; i < 24; i++)
      begin
         k = $urandom % 3;
         m = 2'($urandom);
         @(posedge CLOCK);
         wr(3'h1 << k, 2'h0, m);
         sm[2*k +: 2] = m;
         @(negedge CLOCK);
         chk({2'h0, SPI_MODES}, {2'h0, sm});
      end
      SPI_EN <= 1'b1;
      act <= 1'b1;
      for (i = 0; i < 12; i++)
      begin
         @(posedge CLOCK);
         SPI_MASTER <= i[2];
         {SPI_DO, SPI_SO, SPI_SCK_OUT} <= 3'($urandom);
         @(negedge CLOCK);
         chk({5'h0, SPI_PIN_OE_N}, {5'h0, spi_oe(SPI_MASTER)});
         chk({5'h0, SPI_PIN_O & ~spi_oe(SPI_MASTER)}, {5'h0, SPI_MASTER ?
             {SPI_SCK_OUT, 1'b0, SPI_DO} : {1'b0, SPI_SO, 1'b0}});
         chk({5'h0, SPI_PORT_IN}, {5'h0, h2});
         chk({5'h0, SPI_SCK_IN, SPI_MISO_IN, SPI_MOSI_IN}, {5'h0, h2});
      end
      @(posedge CLOCK);
      wr(3'h0, 2'h2, 2'h1);
      TRIM_CLKEN <= 1'b1;
      for (i = 0; i < 8; i++)
      begin
         {RTC_XTAL, CPU_CLK_SRC} <= 3'(i);
         OSC_AMP_OUT <= 1'($urandom);
         @(negedge CLOCK);
         chk({5'h0, OSC_PIN_OE_N, DIVIDED_CLOCK_OUTPUT_ACTIVE}, {5'h0, i > 1,
             1'b0, i < 3});
         if (i > 2)
            chk({7'h0, OSC_PIN_O[0]}, {7'h0, OSC_AMP_OUT});
         @(posedge CLOCK);
      end
      {TRIM_CLKEN, RTC_XTAL, CPU_CLK_SRC} <= 4'h0;
      @(negedge CLOCK);
      chk({6'h0, OSC_PIN_OE_N}, 8'h01);
      // Oscillator inputs through the synchronisers, then a frozen write
      OSC_PIN_I <= 2'h2;
      repeat (3) @(posedge CLOCK);
      @(negedge CLOCK);
      chk({6'h0, OSC_PORT_IN}, 8'h02);
      chk({7'h0, OSC_AMP_IN}, 8'h01);
      chk({6'h0, OSC_LATCH}, 8'h01);
      CE <= 1'b0;
      @(posedge CLOCK);
      wr(3'h7, 2'h3, 2'h3);
      @(negedge CLOCK);
      chk({2'h0, SPI_MODES}, {2'h0, sm});
      chk({4'h0, OSC_MODES}, 8'h06);
      CE <= 1'b1;
      finish_test();
   end
endmodule : tb_top
`default_nettype wire
